/* focr_pkg.sv */
package focr_pkg;
  // ==========================================================
  // Register map, byte addresses on the word bus
  localparam logic [7:0] FOCR_FOC_IDX = 8'h19;
  localparam logic [7:0] FOCR_CLK_IDX = 8'h1A;
  localparam logic [9:0] FOCR_FOC_ADDR = {FOCR_FOC_IDX, 2'b00};
  localparam logic [9:0] FOCR_CLK_ADDR = {FOCR_CLK_IDX, 2'b00};
  localparam logic [9:0] FOCR_STAT_ADDR = 10'h070;
  // ==========================================================
  // Field positions
  localparam int FOCR_GATE_BIT = 5;
  localparam int FOCR_FPRE_LSB = 3;
  localparam int FOCR_FPOST_BIT = 2;
  localparam int FOCR_FLIM_LSB = 0;
  localparam int FOCR_KI_LSB = 6;
  localparam int FOCR_KP_LSB = 4;
  localparam int FOCR_KIPOST_BIT = 3;
  // ==========================================================
  // Reset values and write masks
  localparam logic [7:0] FOCR_FOC_RST = 8'h36;
  localparam logic [7:0] FOCR_CLK_RST = 8'h68;
  localparam logic [7:0] FOCR_FOC_MASK = 8'h3F;
  localparam logic [7:0] FOCR_CLK_MASK = 8'hF8;
  // Gain code: multiple of base in halves (1 = K/2, 2 = K ... 8 = 4K)
  localparam logic [3:0] FOCR_GAIN_HALF = 4'h1;
endpackage : focr_pkg

/* focr_gain_if.sv */
`timescale 1ns/100ps
// Loop phase carrier between the top and the gain selector
interface focr_gain_if;
  logic post_sync;
  logic frozen;
  modport ctrl (output post_sync, output frozen);
  modport sel (input post_sync, input frozen);
endinterface : focr_gain_if

/* focr_gain_sel.sv */
`timescale 1ns/100ps
module focr_gain_sel
  import focr_pkg::*;
(
  input wire logic [7:0] foc_cfg,
  input wire logic [7:0] clk_cfg,
  focr_gain_if.sel ph,
  output logic [3:0] freq_gain,
  output logic [3:0] ki_gain,
  output logic [3:0] kp_gain,
  output logic [1:0] sat_code,
  output logic loops_run
);
  // Two-bit field to gain in halves of the base
  function automatic logic [3:0] focr_mult(input logic [1:0] f);
    return {1'b0, f, 1'b0} + 4'h2;
  endfunction : focr_mult

  // Gain choice by loop phase
  always_comb begin
    freq_gain = focr_mult(foc_cfg[FOCR_FPRE_LSB +: 2]);
    if (ph.post_sync && foc_cfg[FOCR_FPOST_BIT]) begin
      freq_gain = FOCR_GAIN_HALF;
    end
    ki_gain = focr_mult(clk_cfg[FOCR_KI_LSB +: 2]);
    if (ph.post_sync && clk_cfg[FOCR_KIPOST_BIT]) begin
      ki_gain = FOCR_GAIN_HALF;
    end
    kp_gain = focr_mult(clk_cfg[FOCR_KP_LSB +: 2]);
    sat_code = foc_cfg[FOCR_FLIM_LSB +: 2];
    loops_run = !ph.frozen;
  end
endmodule : focr_gain_sel

/* focr_top.sv */
// Chosen here: register access over Avalon-MM.
`timescale 1ns/100ps
module focr_top
  import focr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic carrier_sense,
  input wire logic sync_detect,
  input wire logic rx_start,
  output logic [3:0] freq_gain_r,
  output logic [3:0] ki_gain_r,
  output logic [3:0] kp_gain_r,
  output logic [1:0] sat_code_r,
  output logic loops_run_r
);
  // ==========================================================
  // Register bus: one wait cycle, answer on the second edge
  logic [7:0] foc_r, foc_nxt, clk_r, clk_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] rd_nxt;
  logic post_r, post_nxt, frz_r, frz_nxt;
  logic [3:0] fg, kig, kpg;
  logic [1:0] sc;
  logic run;
  focr_gain_if ph ();

  // Checks run on the one clock and sleep through reset
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Bus decode; a write is taken when ack_r is high, read data is loaded while it is low
  always_comb begin
    foc_nxt = foc_r;
    clk_nxt = clk_r;
    ack_nxt = (avs_read || avs_write) && !ack_r;
    rd_nxt = avs_readdata;
    if (ack_r && avs_write) begin
      if (avs_address == FOCR_FOC_ADDR) foc_nxt = avs_writedata[7:0] & FOCR_FOC_MASK;
      if (avs_address == FOCR_CLK_ADDR) clk_nxt = avs_writedata[7:0] & FOCR_CLK_MASK;
    end
    if (!ack_r && avs_read) begin
      unique case (avs_address)
        FOCR_FOC_ADDR: rd_nxt = {24'h000000, foc_r};
        FOCR_CLK_ADDR: rd_nxt = {24'h000000, clk_r};
        FOCR_STAT_ADDR: rd_nxt = {29'h0000000, loops_run_r, frz_r, post_r};
        default: rd_nxt = 32'h00000000;
      endcase
    end
  end

  // ==========================================================
  // Loop phase tracking
  always_comb begin
    post_nxt = post_r;
    frz_nxt = frz_r;
    // sync flips to post, new reception returns
    if (rx_start) begin
      post_nxt = 1'b0;
      frz_nxt = foc_r[FOCR_GATE_BIT];
    end else if (sync_detect) begin
      post_nxt = 1'b1;
    end
    // carrier releases freeze; clearing gate bit too
    if (carrier_sense || !foc_r[FOCR_GATE_BIT]) frz_nxt = 1'b0;
  end

  assign ph.post_sync = post_nxt;
  assign ph.frozen = frz_nxt;

  focr_gain_sel u_sel (
    .foc_cfg(foc_r),
    .clk_cfg(clk_r),
    .ph(ph),
    .freq_gain(fg),
    .ki_gain(kig),
    .kp_gain(kpg),
    .sat_code(sc),
    .loops_run(run)
  );

  // ==========================================================
  // Bus registers; reset leaves the documented field defaults
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      foc_r <= FOCR_FOC_RST;
      clk_r <= FOCR_CLK_RST;
      ack_r <= 1'b0;
      avs_readdata <= 32'h00000000;
    end else begin
      foc_r <= foc_nxt;
      clk_r <= clk_nxt;
      ack_r <= ack_nxt;
      avs_readdata <= rd_nxt;
    end
  end

  // Phase and gain registers; gains registered so outputs come from flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      post_r <= 1'b0;
      frz_r <= 1'b1;
      freq_gain_r <= 4'h6;
      ki_gain_r <= 4'h4;
      kp_gain_r <= 4'h6;
      sat_code_r <= 2'h2;
      loops_run_r <= 1'b0;
    end else begin
      post_r <= post_nxt;
      frz_r <= frz_nxt;
      freq_gain_r <= fg;
      ki_gain_r <= kig;
      kp_gain_r <= kpg;
      sat_code_r <= sc;
      loops_run_r <= run;
    end
  end

  assign avs_waitrequest = !ack_r;

  // ==========================================================
  // Bus timing checks
  // answer after one wait
  chk_bus_answer: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  chk_wait_one: assert property (
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  chk_bus_idle: assert property (
    !avs_read && !avs_write |=> avs_waitrequest)
    else $error("answer without request");
  chk_read_stand: assert property (
    !avs_waitrequest |=> $stable(avs_readdata))
    else $error("read data changed after answer");
  chk_unmapped_zero: assert property (
    avs_read && avs_waitrequest && avs_address != FOCR_FOC_ADDR
      && avs_address != FOCR_CLK_ADDR && avs_address != FOCR_STAT_ADDR
      |=> avs_readdata == 32'h00000000)
    else $error("unmapped read not zero");
  chk_clk_write: assert property (
    avs_write && !avs_waitrequest && avs_address == FOCR_CLK_ADDR
      |=> clk_r == ($past(avs_writedata[7:0]) & FOCR_CLK_MASK))
    else $error("clock recovery write lost");
  chk_foc_write: assert property (
    avs_write && !avs_waitrequest && avs_address == FOCR_FOC_ADDR
      |=> foc_r == ($past(avs_writedata[7:0]) & FOCR_FOC_MASK))
    else $error("freq config write lost");

  // ==========================================================
  // Gain checks
  // post-sync half gain
  chk_sync_half_gain: assert property (
    sync_detect && !rx_start && foc_r[2] |=> freq_gain_r == 4'h1)
    else $error("freq gain not K/2 after sync");
  chk_freq_keep: assert property (
    sync_detect && !rx_start && !foc_r[FOCR_FPOST_BIT]
      |=> freq_gain_r == {1'b0, $past(foc_r[4:3]), 1'b0} + 4'h2)
    else $error("freq gain not kept after sync");
  chk_rx_pre_gain: assert property (
    rx_start |=> freq_gain_r == {1'b0, $past(foc_r[4:3]), 1'b0} + 4'h2)
    else $error("pre-sync freq gain wrong");
  chk_ki_post: assert property (
    sync_detect && !rx_start && clk_r[3] |=> ki_gain_r == 4'h1)
    else $error("integral gain not K/2 after sync");
  chk_ki_keep: assert property (
    sync_detect && !rx_start && !clk_r[FOCR_KIPOST_BIT]
      |=> ki_gain_r == {1'b0, $past(clk_r[7:6]), 1'b0} + 4'h2)
    else $error("integral gain not kept after sync");
  chk_kp_follow: assert property (
    ##1 kp_gain_r == {1'b0, $past(clk_r[5:4]), 1'b0} + 4'h2)
    else $error("proportional gain wrong");
  chk_ki_pre: assert property (
    rx_start |=> ki_gain_r == {1'b0, $past(clk_r[7:6]), 1'b0} + 4'h2)
    else $error("pre-sync integral gain wrong");
  chk_sat_follow: assert property (
    ##1 sat_code_r == $past(foc_r[1:0]))
    else $error("saturation code wrong");

  // ==========================================================
  // Phase checks
  // gate freezes at reception
  chk_gate_freeze: assert property (
    rx_start && foc_r[5] && !carrier_sense |=> !loops_run_r)
    else $error("loops ran before carrier sense");
  chk_freeze_hold: assert property (
    frz_r && foc_r[FOCR_GATE_BIT] && !carrier_sense |=> !loops_run_r)
    else $error("frozen loops started early");
  chk_cs_release: assert property (
    carrier_sense |=> loops_run_r)
    else $error("loops still frozen after carrier");
  chk_gate_off_run: assert property (
    !foc_r[FOCR_GATE_BIT] |=> loops_run_r)
    else $error("loops frozen with gate clear");
  chk_rx_post_clear: assert property (
    rx_start |=> !post_r)
    else $error("post phase not cleared");
  chk_sync_post: assert property (
    sync_detect && !rx_start |=> post_r)
    else $error("post phase not entered");
  chk_post_hold: assert property (
    post_r && !rx_start |=> post_r)
    else $error("post phase dropped early");
  chk_status_read: assert property (
    avs_read && avs_waitrequest && avs_address == FOCR_STAT_ADDR
      |=> avs_readdata == {29'h0000000, $past(loops_run_r), $past(frz_r), $past(post_r)})
    else $error("status read wrong");

  // ==========================================================
  // Coverage of the main scenarios
  cov_sync: cover property (rx_start ##[1:20] sync_detect);
  cov_freeze: cover property (!loops_run_r ##1 loops_run_r);
  cov_write: cover property (avs_write && !avs_waitrequest);
  cov_status_read: cover property (avs_read && !avs_waitrequest && avs_address == FOCR_STAT_ADDR);
  cov_post_half: cover property (post_r && freq_gain_r == FOCR_GAIN_HALF);
endmodule : focr_top

/* focr_host_model.sv */
`timescale 1ns/100ps
// ==========================================
// Host side of the register bus
module focr_host_model
  import focr_pkg::*;
(
  input wire logic clk,
  output logic [9:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  // Idle bus from time zero
  initial begin
    avs_address = 10'h000;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
  end
  // Request held until the edge that sees waitrequest low
  task automatic access(input logic wr, input logic [9:0] adr, input logic [7:0] dat,
                        output logic [31:0] q);
    @(posedge clk);
    avs_address <= adr;
    avs_read <= ~wr;
    avs_write <= wr;
    avs_writedata <= {24'h000000, dat};
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : access
  // limit cleared for OOK
  // The device cannot compensate OOK, so the limit must not stay set
  task automatic cfg_freq(input logic [7:0] v, input logic ook);
    logic [31:0] q;
    access(1'b1, FOCR_FOC_ADDR, ook ? (v & 8'hFC) : v, q);
  endtask : cfg_freq
endmodule : focr_host_model

/* tb_freq_offset_clock_recovery_cfg.sv */
`timescale 1ns/100ps
module tb_freq_offset_clock_recovery_cfg
  import focr_pkg::*;
;
  logic clk, rst_n, carrier_sense, sync_detect, rx_start, rd, wr, wt, run;
  logic [9:0] adr;
  logic [31:0] wd, rdat, q;
  logic [3:0] fg, ki, kp;
  logic [1:0] sat;
  int miscompares, checked, cycles;
  // Rows: foc, clk, freq, ki, kp, sat (gain in halves of K)
  logic [29:0] rows [4] = '{{8'h00, 8'h00, 4'h2, 4'h2, 4'h2, 2'h0},
    {8'h09, 8'h50, 4'h4, 4'h4, 4'h4, 2'h1}, {8'h12, 8'hA0, 4'h6, 4'h6, 4'h6, 2'h2},
    {8'h1B, 8'hF0, 4'h8, 4'h8, 4'h8, 2'h3}};
  focr_top i_dut (.clk(clk), .rst_n(rst_n), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wd), .avs_readdata(rdat), .avs_waitrequest(wt),
    .carrier_sense(carrier_sense), .sync_detect(sync_detect), .rx_start(rx_start),
    .freq_gain_r(fg), .ki_gain_r(ki), .kp_gain_r(kp), .sat_code_r(sat), .loops_run_r(run));
  focr_host_model i_host (.clk(clk), .avs_address(adr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wd), .avs_readdata(rdat), .avs_waitrequest(wt));
  // ==========================================
  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      miscompares++;
      complete_run();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Outputs settle one edge after their cause; look mid-cycle
  // Sel picks the line: 0 new reception, 1 sync found, other carrier sense
  task automatic pulse(input int sel);
    @(posedge clk);
    case (sel)
      0: rx_start <= 1'b1;
      1: sync_detect <= 1'b1;
      default: carrier_sense <= 1'b1;
    endcase
    @(posedge clk);
    {rx_start, sync_detect, carrier_sense} <= 3'b000;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask : pulse
  task automatic complete_run();
    $display("miscompares=%0d checked=%0d", miscompares, checked);
    if (miscompares == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : complete_run
  // ==========================================
  // Main sequence
  initial begin
    {rst_n, carrier_sense, sync_detect, rx_start, miscompares, checked, cycles} = '0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk({fg, ki, kp, sat, run}, {4'h6, 4'h4, 4'h6, 2'h2, 1'b0});
    i_host.access(1'b0, FOCR_FOC_ADDR, 8'h00, q);
    chk(q, 32'h36);
    i_host.access(1'b0, FOCR_CLK_ADDR, 8'h00, q);
    chk(q, 32'h68);
    foreach (rows[i]) begin
      i_host.cfg_freq(rows[i][29:22], 1'b0);
      i_host.access(1'b1, FOCR_CLK_ADDR, rows[i][21:14], q);
      pulse(0);
      chk({fg, ki, kp, sat, run}, {rows[i][13:0], 1'b1});
    end
    pulse(1);
    chk({fg, ki}, 8'h88);
    i_host.cfg_freq(8'h1F, 1'b1);
    i_host.access(1'b1, FOCR_CLK_ADDR, 8'hF8, q);
    pulse(0);
    chk({fg, ki, sat}, 10'h220);
    pulse(1);
    chk({fg, ki}, 8'h11);
    i_host.access(1'b0, FOCR_STAT_ADDR, 8'h00, q);
    chk(q, 32'h00000005);
    pulse(0);
    chk({fg, ki}, 8'h88);
    i_host.cfg_freq(8'hFF, 1'b0);
    pulse(0);
    chk(run, 1'b0);
    i_host.access(1'b0, FOCR_STAT_ADDR, 8'h00, q);
    chk(q, 32'h00000002);
    pulse(2);
    chk(run, 1'b1);
    i_host.access(1'b1, 10'h07C, 8'h00, q);
    i_host.access(1'b0, FOCR_FOC_ADDR, 8'h00, q);
    chk(q, 32'h3F);
    i_host.access(1'b1, FOCR_CLK_ADDR, 8'hFF, q);
    i_host.access(1'b0, FOCR_CLK_ADDR, 8'h00, q);
    chk(q, 32'hF8);
    i_host.access(1'b0, 10'h07C, 8'h00, q);
    chk(q, 32'h0);
    // Mid-run reset: fields and gains return to their defaults
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk({fg, ki, kp, sat, run}, {4'h6, 4'h4, 4'h6, 2'h2, 1'b0});
    i_host.access(1'b0, FOCR_FOC_ADDR, 8'h00, q);
    chk(q, {24'h000000, FOCR_FOC_RST});
    i_host.access(1'b0, FOCR_CLK_ADDR, 8'h00, q);
    chk(q, {24'h000000, FOCR_CLK_RST});
    complete_run();
  end
endmodule : tb_freq_offset_clock_recovery_cfg
